// file: logic/watchdog_pkg.sv
package watchdog_pkg;

  localparam int unsigned CTL_W          = 8;
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned PRESCALE_W     = 4;

  // Control register field positions
  localparam int unsigned UNLOCK_BIT     = 0;
  localparam int unsigned ENABLE_BIT     = 1;
  localparam int unsigned STATUS_BIT     = 2;
  localparam int unsigned IRQ_SEL_BIT    = 3;
  localparam int unsigned PRESCALE_LSB   = 4;

  localparam logic [CTL_W-1:0]      CTL_RESET      = 8'h00;
  localparam logic [CNT_W-1:0]      CNT_ZERO       = 16'h0000;
  localparam logic [CNT_W-1:0]      CNT_ONE        = 16'h0001;
  // Shortest period in base ticks; each prescale step up to PRESCALE_MAX doubles it, higher settings clamp there
  localparam logic [CNT_W-1:0]      BASE_PERIOD    = 16'h0010;
  localparam logic [PRESCALE_W-1:0] PRESCALE_MAX   = 4'hB;

  // One core write into the control register
  typedef struct packed {
    logic             strobe;
    logic [CTL_W-1:0] data;
  } ctl_write_type;

  // Timeout action pulses towards the chip
  typedef struct packed {
    logic chip_reset;
    logic irq;
  } timeout_action_type;

endpackage

// file: logic/watchdog_control_status.sv
`timescale 1ns/1ps
// Behaviour
// RQ1 - Timeout sets status; write 0 or hardware reset clears
// RQ2 - Setting enable restarts the timeout count
// RQ3 - Unrefreshed timeout gives chip reset or interrupt
// RQ4 - Enable cleared by write0, reset, supply interrupt
// RQ5 - Control write only right after unlock set
// RQ6 - Software masks interrupts around the unlock sequence
// RQ7 - Interrupt mode: fixed high-priority unmaskable timeout interrupt
// RQ8 - Unlock permission lapses after the next instruction
module watchdog_control_status (
  // Clock and hardware reset
  input  wire logic                          sys_clk_in,
  input  wire logic                          rst_in,
  // Core register access
  input  wire watchdog_pkg::ctl_write_type   ctl_write_in,
  input  wire logic                          unlock_set_in,
  input  wire logic                          instr_end_in,
  output logic [watchdog_pkg::CTL_W-1:0]     ctl_read_out,
  // Time base and system events
  input  wire logic                          base_tick_in,
  input  wire logic                          supply_monitor_irq_in,
  // Timeout actions
  output watchdog_pkg::timeout_action_type   action_out
);

  logic                                enable_r;
  logic                                status_r;
  logic                                irq_sel_r;
  logic                                unlock_r;
  logic [watchdog_pkg::PRESCALE_W-1:0] prescale_r;
  logic [watchdog_pkg::CNT_W-1:0]      count_r;
  logic                                write_ok;
  logic                                enable_write;
  logic                                timeout;
  logic [watchdog_pkg::CTL_W-1:0]      ctl_view;

  function automatic logic [watchdog_pkg::CNT_W-1:0] period_of(
    input logic [watchdog_pkg::PRESCALE_W-1:0] ps
  );
    logic [watchdog_pkg::PRESCALE_W-1:0] lim;
    lim = (ps > watchdog_pkg::PRESCALE_MAX) ? watchdog_pkg::PRESCALE_MAX : ps;
    return watchdog_pkg::BASE_PERIOD << lim;
  endfunction

  // The unlock is a one-shot so a stray store cannot reconfigure the dog
  assign write_ok     = ctl_write_in.strobe && unlock_r;  // RQ5
  assign enable_write = write_ok && ctl_write_in.data[watchdog_pkg::ENABLE_BIT];
  assign timeout      = enable_r && base_tick_in
                        && (count_r == period_of(prescale_r) - watchdog_pkg::CNT_ONE);

  // Unlock arms on its set and lapses at the end of the next instruction
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      unlock_r <= 1'b0;
    end else if (unlock_set_in) begin
      unlock_r <= 1'b1;
    end else if (instr_end_in || write_ok) begin
      unlock_r <= 1'b0;  // RQ8
    end
  end

  // Period and response select
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prescale_r <= watchdog_pkg::CTL_RESET[watchdog_pkg::PRESCALE_LSB
                                             +: watchdog_pkg::PRESCALE_W];
      irq_sel_r  <= watchdog_pkg::CTL_RESET[watchdog_pkg::IRQ_SEL_BIT];
    end else if (write_ok) begin
      prescale_r <= ctl_write_in.data[watchdog_pkg::PRESCALE_LSB +: watchdog_pkg::PRESCALE_W];
      irq_sel_r  <= ctl_write_in.data[watchdog_pkg::IRQ_SEL_BIT];
    end
  end

  // Enable bit
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      enable_r <= watchdog_pkg::CTL_RESET[watchdog_pkg::ENABLE_BIT];  // RQ4
    end else if (write_ok) begin
      enable_r <= ctl_write_in.data[watchdog_pkg::ENABLE_BIT];  // RQ4
    end else if (supply_monitor_irq_in) begin
      enable_r <= 1'b0;  // RQ4
    end else if (timeout && !irq_sel_r) begin
      enable_r <= 1'b0;  // RQ4
    end
  end

  // Timeout status: a timeout in the clearing cycle still lands
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_r <= watchdog_pkg::CTL_RESET[watchdog_pkg::STATUS_BIT];  // RQ1
    end else if (timeout) begin
      status_r <= 1'b1;  // RQ1
    end else if (write_ok) begin
      status_r <= ctl_write_in.data[watchdog_pkg::STATUS_BIT];  // RQ1
    end
  end

  // Timeout counter; a fresh enable restarts it from zero
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_r <= watchdog_pkg::CNT_ZERO;
    end else if (enable_write || !enable_r || timeout) begin
      count_r <= watchdog_pkg::CNT_ZERO;  // RQ2
    end else if (base_tick_in) begin
      count_r <= count_r + watchdog_pkg::CNT_ONE;
    end
  end

  // Action pulses; the interrupt is independent of global masking upstream
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      action_out <= '0;
    end else begin
      action_out.chip_reset <= timeout && !irq_sel_r;  // RQ3
      action_out.irq        <= timeout && irq_sel_r;  // RQ7
    end
  end

  // Readback image placed by the package field map, not by bit order
  always_comb begin
    ctl_view                                                        = watchdog_pkg::CTL_RESET;
    ctl_view[watchdog_pkg::UNLOCK_BIT]                              = unlock_r;
    ctl_view[watchdog_pkg::ENABLE_BIT]                              = enable_r;
    ctl_view[watchdog_pkg::STATUS_BIT]                              = status_r;
    ctl_view[watchdog_pkg::IRQ_SEL_BIT]                             = irq_sel_r;
    ctl_view[watchdog_pkg::PRESCALE_LSB +: watchdog_pkg::PRESCALE_W] = prescale_r;
  end

  // Readback
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_read_out <= watchdog_pkg::CTL_RESET;
    end else begin
      ctl_read_out <= ctl_view;
    end
  end

  // Assertions
  locked_write_ignored_a: assert property (  // RQ5
    @(posedge sys_clk_in) disable iff (rst_in)
    ctl_write_in.strobe && !unlock_r && !timeout && !supply_monitor_irq_in
    |=> $stable(enable_r) && $stable(irq_sel_r) && $stable(prescale_r))
    else $error("locked control write changed state");

  unlocked_write_a: assert property (  // RQ5
    @(posedge sys_clk_in) disable iff (rst_in)
    write_ok && !timeout && !supply_monitor_irq_in
    |=> enable_r == $past(ctl_write_in.data[watchdog_pkg::ENABLE_BIT])
        && irq_sel_r == $past(ctl_write_in.data[watchdog_pkg::IRQ_SEL_BIT]))
    else $error("unlocked write not taken");

  unlock_arm_a: assert property (  // RQ5
    @(posedge sys_clk_in) disable iff (rst_in)
    unlock_set_in |=> unlock_r)
    else $error("unlock set did not arm");

  unlock_lapse_a: assert property (  // RQ8
    @(posedge sys_clk_in) disable iff (rst_in)
    unlock_r && instr_end_in && !unlock_set_in |=> !unlock_r)
    else $error("unlock outlived next instruction");

  status_set_a: assert property (  // RQ1
    @(posedge sys_clk_in) disable iff (rst_in)
    timeout |=> status_r)
    else $error("timeout did not set status");

  status_hold_a: assert property (  // RQ1
    @(posedge sys_clk_in) disable iff (rst_in)
    status_r && !write_ok |=> status_r)
    else $error("status cleared without a write");

  status_clear_a: assert property (  // RQ1
    @(posedge sys_clk_in) disable iff (rst_in)
    write_ok && !ctl_write_in.data[watchdog_pkg::STATUS_BIT] && !timeout |=> !status_r)
    else $error("status write of zero not taken");

  restart_count_a: assert property (  // RQ2
    @(posedge sys_clk_in) disable iff (rst_in)
    enable_write |=> count_r == watchdog_pkg::CNT_ZERO)
    else $error("enable did not restart count");

  count_bound_a: assert property (  // RQ3
    @(posedge sys_clk_in) disable iff (rst_in)
    enable_r |-> count_r < period_of(prescale_r))
    else $error("count ran past the period");

  reset_action_a: assert property (  // RQ3
    @(posedge sys_clk_in) disable iff (rst_in)
    timeout && !irq_sel_r && !write_ok
    |=> action_out.chip_reset && !action_out.irq && !enable_r)
    else $error("reset response wrong");

  action_pulse_a: assert property (  // RQ3
    @(posedge sys_clk_in) disable iff (rst_in)
    action_out.chip_reset || action_out.irq |=> !action_out.chip_reset && !action_out.irq)
    else $error("timeout action longer than one cycle");

  irq_action_a: assert property (  // RQ7
    @(posedge sys_clk_in) disable iff (rst_in)
    timeout && irq_sel_r |=> action_out.irq && !action_out.chip_reset)
    else $error("interrupt response wrong");

  irq_keeps_running_a: assert property (  // RQ7
    @(posedge sys_clk_in) disable iff (rst_in)
    timeout && irq_sel_r && !write_ok && !supply_monitor_irq_in
    |=> enable_r && count_r == watchdog_pkg::CNT_ZERO)
    else $error("interrupt mode did not restart the period");

  supply_clear_a: assert property (  // RQ4
    @(posedge sys_clk_in) disable iff (rst_in)
    supply_monitor_irq_in && !write_ok |=> !enable_r)
    else $error("supply interrupt left dog enabled");

  readback_a: assert property (  // RQ1
    @(posedge sys_clk_in) disable iff (rst_in)
    ctl_read_out == $past(ctl_view))
    else $error("readback does not follow state");

  cov_reset_c: cover property (@(posedge sys_clk_in) disable iff (rst_in) action_out.chip_reset);
  cov_irq_c: cover property (@(posedge sys_clk_in) disable iff (rst_in) action_out.irq);
  cov_lapse_c: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    unlock_r && instr_end_in ##1 ctl_write_in.strobe);
  cov_refresh_c: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    enable_r && enable_write);
  cov_supply_c: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    enable_r && supply_monitor_irq_in);

endmodule

// file: verif/watchdog_control_status_bench.sv
`timescale 1ns/1ps
module watchdog_control_status_bench;
  logic                                sys_clk_in;
  logic                                rst_in;
  watchdog_pkg::ctl_write_type         ctl_write_in;
  logic                                unlock_set_in;
  logic                                instr_end_in;
  logic [watchdog_pkg::CTL_W-1:0]      ctl_read_out;
  logic                                base_tick_in;
  logic                                supply_monitor_irq_in;
  watchdog_pkg::timeout_action_type    action_out;
  int                                  err_count;
  int                                  n_checks;
  int                                  rc;
  int                                  ic;
  int                                  r0;
  int                                  i0;

  watchdog_control_status i_watchdog_control_status (
    .sys_clk_in            (sys_clk_in),
    .rst_in                (rst_in),
    .ctl_write_in          (ctl_write_in),
    .unlock_set_in         (unlock_set_in),
    .instr_end_in          (instr_end_in),
    .ctl_read_out          (ctl_read_out),
    .base_tick_in          (base_tick_in),
    .supply_monitor_irq_in (supply_monitor_irq_in),
    .action_out            (action_out)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  // Pulse counters; scenarios compare deltas so no scenario writes them
  always @(posedge sys_clk_in) begin
    if (action_out.chip_reset === 1'b1) rc++;
    if (action_out.irq === 1'b1) ic++;
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic clk(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // Optional unlock, optionally one stray instruction, then the store; readback settles after
  task automatic wr(input logic [7:0] d, input bit stray, input bit unlock);
    clk(1);
    unlock_set_in <= unlock;
    instr_end_in  <= 1'b1;
    clk(1);
    unlock_set_in <= 1'b0;
    instr_end_in  <= stray;
    clk(1);
    instr_end_in        <= 1'b1;
    ctl_write_in.strobe <= 1'b1;
    ctl_write_in.data   <= d;
    clk(1);
    instr_end_in        <= 1'b0;
    ctl_write_in.strobe <= 1'b0;
    clk(2);
    #1;
  endtask

  task automatic ticks(input int n);
    clk(1);
    repeat (n) begin
      base_tick_in <= 1'b1;
      clk(1);
      base_tick_in <= 1'b0;
      clk(1);
    end
    clk(2);
    #1;
  endtask

  task automatic t_lock_and_reset_mode();
    chk("ctl after reset", 8'h00, ctl_read_out);
    wr(8'h02, 1'b0, 1'b0);
    chk("locked store", 8'h00, ctl_read_out);
    wr(8'h02, 1'b0, 1'b1);
    chk("enable store", 8'h02, ctl_read_out);
    r0 = rc;
    i0 = ic;
    ticks(16);
    chk("chip resets", 8'h01, 8'(rc - r0));
    chk("irqs in reset mode", 8'h00, 8'(ic - i0));
    chk("ctl after timeout", 8'h04, ctl_read_out);
  endtask

  task automatic t_irq_mode_restart();
    wr(8'h0A, 1'b0, 1'b1);
    chk("status cleared", 8'h0A, ctl_read_out);
    r0 = rc;
    i0 = ic;
    ticks(10);
    wr(8'h0A, 1'b0, 1'b1);
    ticks(10);
    chk("irq after restart", 8'h00, 8'(ic - i0));
    ticks(6);
    chk("irq on timeout", 8'h01, 8'(ic - i0));
    chk("no chip reset", 8'h00, 8'(rc - r0));
    chk("ctl irq mode", 8'h0E, ctl_read_out);
  endtask

  task automatic t_supply_lapse_hwreset();
    clk(1);
    supply_monitor_irq_in <= 1'b1;
    clk(1);
    supply_monitor_irq_in <= 1'b0;
    clk(2);
    #1;
    chk("supply clears enable", 8'h0C, ctl_read_out);
    wr(8'h00, 1'b1, 1'b1);
    chk("lapsed unlock", 8'h0C, ctl_read_out);
    clk(1);
    rst_in <= 1'b1;
    clk(2);
    rst_in <= 1'b0;
    clk(2);
    #1;
    chk("hardware reset", 8'h00, ctl_read_out);
  endtask

  // Prescale step 1 doubles the period to 32 base ticks
  task automatic t_prescale_period();
    wr(8'h1A, 1'b0, 1'b1);
    chk("ctl prescale one", 8'h1A, ctl_read_out);
    r0 = rc;
    i0 = ic;
    ticks(31);
    chk("irq before long period", 8'h00, 8'(ic - i0));
    ticks(1);
    chk("irq at long period", 8'h01, 8'(ic - i0));
    chk("no chip reset long", 8'h00, 8'(rc - r0));
    chk("ctl after long period", 8'h1E, ctl_read_out);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    {rst_in, unlock_set_in, instr_end_in, base_tick_in, supply_monitor_irq_in} = 5'h10;
    ctl_write_in = '0;
    err_count = 0;
    n_checks = 0;
    rc = 0;
    ic = 0;
    clk(4);
    rst_in <= 1'b0;
    clk(1);
    #1;
    t_lock_and_reset_mode();
    t_irq_mode_restart();
    t_supply_lapse_hwreset();
    t_prescale_period();
    summarize();
  end
endmodule
